// file: hw/tsl_pkg.sv
// shared constants for the touch register slave link and its host end
// assumes a 10 MHz system clock on both ends
package tsl_pkg;
   // =========================================================
   // addresses, byte layout
   localparam logic [7:0] ADDR_PAIR0_WR = 8'hBA;
   localparam logic [7:0] ADDR_PAIR1_WR = 8'h28;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [2:0] STG_PTR_HI    = 3'h0;
   localparam logic [2:0] STG_PTR_LO    = 3'h1;
   localparam logic [2:0] STG_DATA      = 3'h2;
   localparam logic [2:0] STG_ADDR_WR   = 3'h3;
   localparam logic [2:0] STG_ADDR_RD   = 3'h4;
   localparam logic [2:0] STG_READ      = 3'h5;
   // =========================================================
   // timing
   localparam int CLK_NS  = 100;
   // quarter of a serial bit; 2.8 us bit keeps the rate below 400 kbit/s
   localparam int QTR_NS  = 700;
   localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
   // host holds reset, then the strap, this long each
   localparam int POR_NS  = 10000;
   localparam int POR_CYC = (POR_NS + CLK_NS - 1) / CLK_NS;
endpackage : tsl_pkg

// file: hw/tsl_link_if.sv
// serial link between the host end and the touch register slave
// open-drain lines resolve here with an implied pull-up
`timescale 1ns/100ps
`default_nettype none
interface tsl_link_if;
   logic h_scl_o, h_scl_oe_n, h_sda_o, h_sda_oe_n;
   logic h_rst_n, h_int_o, h_int_oe_n;
   logic d_sda_o, d_sda_oe_n, d_int_o, d_int_oe_n;
   logic scl, sda, rst_n, int_l;
   // =========================================================
   // wire resolution
   assign scl   = h_scl_oe_n | h_scl_o;
   assign sda   = (h_sda_oe_n | h_sda_o) & (d_sda_oe_n | d_sda_o);
   assign rst_n = h_rst_n;
   // event line: host wins during the strap phase, else device, else low
   assign int_l = !h_int_oe_n ? h_int_o : (!d_int_oe_n ? d_int_o : 1'b0);
   modport dev  (input scl, sda, rst_n, int_l,
                 output d_sda_o, d_sda_oe_n, d_int_o, d_int_oe_n);
   modport host (input sda, int_l,
                 output h_scl_o, h_scl_oe_n, h_sda_o, h_sda_oe_n,
                        h_rst_n, h_int_o, h_int_oe_n);
endinterface : tsl_link_if
`default_nettype wire

// file: hw/tsl_dev.sv
// touch register slave: serial slave with 16-bit auto-increment pointer
// assumes user register logic on CLK_SYS answering REG_RDATA for REG_ADDR
// within one cycle; link pins are asynchronous and synchronised here
//
// Functional notes
// - device only answers, never starts transfers
// - host keeps bit rate at most 400k
// - one selected address pair, write and read
// - host picks pair via reset, event pins
// - data falling while clock high starts
// - capture address byte, ack low ninth clock
// - mismatch: no ack, idle until start
// - nine clocks per byte, receiver acks
// - data sampled high, changed while low
// - data rising while clock high stops
// - write: address, pointer high, low, data
// - pointer increments after each data byte
// - burst write ends only at stop; here a repeated start ends it too
// - read begins with pointer load write
// - repeated start, read address, then data
// - host acks each byte wanting more
// - host nack ends read, device releases
// - device reset pin is active low
// - separate event line toward the host
`timescale 1ns/100ps
`default_nettype none
module tsl_dev (
   input  wire logic        CLK_SYS,
   input  wire logic        RSTN,
   input  wire logic        CE,
   tsl_link_if.dev          LINK,
   input  wire logic        EVENT,
   input  wire logic [7:0]  REG_RDATA,
   output logic      [15:0] REG_ADDR,
   output logic             REG_WR,
   output logic      [7:0]  REG_WDATA,
   output logic             REG_RD,
   output logic             PAIR_SEL
);
   import tsl_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_RX, S_ACK, S_TX, S_TXACK
   } tsl_dst_e;

   function automatic logic [7:0] pair_wr(input logic sel);
      pair_wr = sel ? ADDR_PAIR1_WR : ADDR_PAIR0_WR;
   endfunction : pair_wr

   // =========================================================
   // pin synchronisers: scl, sda, reset, event
   logic [3:0] s1_r, s2_r, pv_r;
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         // link reset reads low until synchronised, so no early strap latch
         s1_r <= 4'hB;
         s2_r <= 4'hB;
         pv_r <= 4'hB;
      end else if (CE) begin
         s1_r <= {LINK.int_l, LINK.rst_n, LINK.sda, LINK.scl};
         s2_r <= s1_r;
         pv_r <= s2_r;
      end
   end

   logic scl, sda, rise, fall, start, stop;
   always_comb begin
      scl   = s2_r[0];
      sda   = s2_r[1];
      rise  = scl & ~pv_r[0];
      fall  = ~scl & pv_r[0];
      start = scl & pv_r[0] & pv_r[1] & ~sda;
      stop  = scl & pv_r[0] & ~pv_r[1] & sda;
   end

   // =========================================================
   // protocol engine
   tsl_dst_e    st_r, st_nxt;
   logic [3:0]  bcnt_r, bcnt_nxt;
   logic [7:0]  shf_r, shf_nxt;
   logic [2:0]  stg_r, stg_nxt;
   logic [15:0] ptr_r, ptr_nxt, addr_r, addr_nxt;
   logic [7:0]  wdat_r, wdat_nxt;
   logic        rw_r, rw_nxt, oe_n_r, oe_n_nxt, more_r, more_nxt;
   logic        wr_r, wr_nxt, rd_r, rd_nxt, sel_r, sel_nxt;
   logic        inrst_r, inrst_nxt, io_r, io_nxt, ioe_n_r, ioe_n_nxt;
   logic [7:0]  own_wr;

   always_comb begin
      st_nxt    = st_r;
      bcnt_nxt  = bcnt_r;
      shf_nxt   = shf_r;
      stg_nxt   = stg_r;
      ptr_nxt   = ptr_r;
      wdat_nxt  = wdat_r;
      rw_nxt    = rw_r;
      oe_n_nxt  = oe_n_r;
      more_nxt  = more_r;
      sel_nxt   = sel_r;
      inrst_nxt = inrst_r;
      wr_nxt    = 1'b0;
      rd_nxt    = 1'b0;
      addr_nxt  = ptr_r;
      own_wr    = pair_wr(sel_r);
      io_nxt    = EVENT;
      ioe_n_nxt = inrst_r;
      if (!s2_r[2]) begin
         inrst_nxt = 1'b1;
         st_nxt    = S_IDLE;
         oe_n_nxt  = 1'b1;
         ioe_n_nxt = 1'b1;
      end else if (inrst_r) begin
         inrst_nxt = 1'b0;
         sel_nxt   = s2_r[3];
      end else if (stop) begin
         st_nxt   = S_IDLE;
         oe_n_nxt = 1'b1;
      end else if (start) begin
         st_nxt   = S_ADDR;
         bcnt_nxt = 4'h0;
         oe_n_nxt = 1'b1;
      end else begin
         unique case (st_r)
            S_IDLE: begin
            end
            S_ADDR, S_RX: begin
               if (rise && bcnt_r < BITS_PER_BYTE) begin
                  shf_nxt  = {shf_r[6:0], sda};
                  bcnt_nxt = bcnt_r + 4'h1;
               end else if (fall && bcnt_r == BITS_PER_BYTE) begin
                  st_nxt   = S_ACK;
                  oe_n_nxt = 1'b0;
                  if (st_r == S_ADDR) begin
                     if (shf_r[7:1] == own_wr[7:1]) begin
                        rw_nxt  = shf_r[0];
                        stg_nxt = STG_PTR_HI;
                     end else begin
                        st_nxt   = S_IDLE;
                        oe_n_nxt = 1'b1;
                     end
                  end else begin
                     unique case (stg_r)
                        STG_PTR_HI: begin
                           ptr_nxt[15:8] = shf_r;
                           stg_nxt       = STG_PTR_LO;
                        end
                        STG_PTR_LO: begin
                           ptr_nxt[7:0] = shf_r;
                           stg_nxt      = STG_DATA;
                        end
                        default: begin
                           wr_nxt   = 1'b1;
                           wdat_nxt = shf_r;
                           ptr_nxt  = ptr_r + 16'h0001;
                        end
                     endcase
                  end
               end
            end
            S_ACK: begin
               if (fall) begin
                  bcnt_nxt = 4'h0;
                  if (rw_r) begin
                     st_nxt   = S_TX;
                     shf_nxt  = REG_RDATA;
                     oe_n_nxt = REG_RDATA[7];
                     rd_nxt   = 1'b1;
                     ptr_nxt  = ptr_r + 16'h0001;
                  end else begin
                     st_nxt   = S_RX;
                     oe_n_nxt = 1'b1;
                  end
               end
            end
            S_TX: begin
               if (fall) begin
                  if (bcnt_r == BITS_PER_BYTE - 4'h1) begin
                     st_nxt   = S_TXACK;
                     oe_n_nxt = 1'b1;
                     more_nxt = 1'b0;
                  end else begin
                     shf_nxt  = {shf_r[6:0], 1'b0};
                     oe_n_nxt = shf_r[6];
                     bcnt_nxt = bcnt_r + 4'h1;
                  end
               end
            end
            S_TXACK: begin
               if (rise) begin
                  if (sda) st_nxt = S_IDLE;
                  else more_nxt = 1'b1;
               end else if (fall && more_r) begin
                  st_nxt   = S_TX;
                  bcnt_nxt = 4'h0;
                  shf_nxt  = REG_RDATA;
                  oe_n_nxt = REG_RDATA[7];
                  rd_nxt   = 1'b1;
                  ptr_nxt  = ptr_r + 16'h0001;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         st_r    <= S_IDLE;
         bcnt_r  <= 4'h0;
         shf_r   <= 8'h00;
         stg_r   <= STG_PTR_HI;
         ptr_r   <= 16'h0000;
         addr_r  <= 16'h0000;
         wdat_r  <= 8'h00;
         rw_r    <= 1'b0;
         oe_n_r  <= 1'b1;
         more_r  <= 1'b0;
         wr_r    <= 1'b0;
         rd_r    <= 1'b0;
         sel_r   <= 1'b0;
         inrst_r <= 1'b1;
         io_r    <= 1'b0;
         ioe_n_r <= 1'b1;
      end else if (CE) begin
         st_r    <= st_nxt;
         bcnt_r  <= bcnt_nxt;
         shf_r   <= shf_nxt;
         stg_r   <= stg_nxt;
         ptr_r   <= ptr_nxt;
         addr_r  <= addr_nxt;
         wdat_r  <= wdat_nxt;
         rw_r    <= rw_nxt;
         oe_n_r  <= oe_n_nxt;
         more_r  <= more_nxt;
         wr_r    <= wr_nxt;
         rd_r    <= rd_nxt;
         sel_r   <= sel_nxt;
         inrst_r <= inrst_nxt;
         io_r    <= io_nxt;
         ioe_n_r <= ioe_n_nxt;
      end
   end

   // =========================================================
   // outputs; sda is open drain so its data bit is always low
   assign LINK.d_sda_o    = 1'b0;
   assign LINK.d_sda_oe_n = oe_n_r;
   assign LINK.d_int_o    = io_r;
   assign LINK.d_int_oe_n = ioe_n_r;
   assign REG_ADDR        = addr_r;
   assign REG_WR          = wr_r;
   assign REG_WDATA       = wdat_r;
   assign REG_RD          = rd_r;
   assign PAIR_SEL        = sel_r;
endmodule : tsl_dev
`default_nettype wire

// file: hw/tsl_host.sv
// host end: resets the touch slave, straps its address pair, then runs
// pointer writes, burst writes and burst reads on user command
// assumes user logic on CLK_SYS; link inputs synchronised here
`timescale 1ns/100ps
`default_nettype none
module tsl_host #(
   parameter int QTR = tsl_pkg::QTR_CYC,
   parameter int POR = tsl_pkg::POR_CYC
) (
   input  wire logic        CLK_SYS,
   input  wire logic        RSTN,
   input  wire logic        CE,
   tsl_link_if.host         LINK,
   input  wire logic        PAIR_SEL,
   input  wire logic        CMD_VALID,
   input  wire logic        CMD_RD,
   input  wire logic [15:0] CMD_PTR,
   input  wire logic [7:0]  CMD_LEN,
   input  wire logic [7:0]  WR_DATA,
   output logic             CMD_READY,
   output logic             WR_TAKE,
   output logic             RD_VALID,
   output logic      [7:0]  RD_DATA,
   output logic             DONE,
   output logic             NACK,
   output logic             EVENT
);
   import tsl_pkg::*;

   if (QTR < 1 || QTR > 255 || POR < 1 || POR > 32767) begin : g_bad
      $error("tsl_host: QTR or POR out of range");
   end

   typedef enum logic [2:0] {
      H_POR, H_IDLE, H_START, H_SEND, H_RECV, H_STOP
   } tsl_hst_e;

   // =========================================================
   // synchronisers: sda, event
   logic [1:0] s1_r, s2_r;
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         s1_r <= 2'h3;
         s2_r <= 2'h3;
      end else if (CE) begin
         s1_r <= {LINK.int_l, LINK.sda};
         s2_r <= s1_r;
      end
   end

   tsl_hst_e    st_r, st_nxt;
   logic [15:0] por_r, por_nxt, ptr_r, ptr_nxt;
   logic [7:0]  cnt_r, cnt_nxt, shf_r, shf_nxt, len_r, len_nxt;
   logic [7:0]  rdat_r, rdat_nxt;
   logic [3:0]  bcnt_r, bcnt_nxt;
   logic [2:0]  stg_r, stg_nxt;
   logic [1:0]  q_r, q_nxt;
   logic        rd_r, rd_nxt, pair_r, pair_nxt, ack_r, ack_nxt;
   logic        scl_n_r, scl_n_nxt, sda_n_r, sda_n_nxt, rst_r, rst_nxt;
   logic        ioe_n_r, ioe_n_nxt, rdy_r, rdy_nxt, take_r, take_nxt;
   logic        rv_r, rv_nxt, done_r, done_nxt, nack_r, nack_nxt, tick;

   always_comb begin
      st_nxt = st_r; por_nxt = por_r; ptr_nxt = ptr_r; len_nxt = len_r;
      shf_nxt = shf_r; rdat_nxt = rdat_r; bcnt_nxt = bcnt_r;
      stg_nxt = stg_r; q_nxt = q_r; rd_nxt = rd_r; pair_nxt = pair_r;
      ack_nxt = ack_r; scl_n_nxt = scl_n_r; sda_n_nxt = sda_n_r;
      rst_nxt = rst_r; ioe_n_nxt = ioe_n_r; rdy_nxt = rdy_r;
      nack_nxt = nack_r;
      take_nxt = 1'b0;
      rv_nxt   = 1'b0;
      done_nxt = 1'b0;
      tick     = (cnt_r == 8'(QTR - 1));
      cnt_nxt  = (tick || st_r == H_IDLE) ? 8'h00 : cnt_r + 8'h01;
      if (tick) q_nxt = q_r + 2'h1;
      unique case (st_r)
         H_POR: begin
            pair_nxt = PAIR_SEL;
            por_nxt  = por_r + 16'h0001;
            if (por_r == 16'(POR)) rst_nxt = 1'b1;
            if (por_r == 16'(2 * POR)) begin
               ioe_n_nxt = 1'b1;
               rdy_nxt   = 1'b1;
               st_nxt    = H_IDLE;
            end
         end
         H_IDLE: begin
            q_nxt = 2'h0;
            if (CMD_VALID) begin
               rdy_nxt  = 1'b0;
               nack_nxt = 1'b0;
               rd_nxt   = CMD_RD;
               ptr_nxt  = CMD_PTR;
               len_nxt  = CMD_LEN;
               stg_nxt  = STG_ADDR_WR;
               st_nxt   = H_START;
            end
         end
         H_START: begin
            if (tick) begin
               unique case (q_r)
                  // wait until the slave has let go of its ack bit
                  2'h0: begin
                     if (s2_r[0]) scl_n_nxt = 1'b1;
                     else q_nxt = q_r;
                  end
                  2'h1: sda_n_nxt = 1'b0;
                  2'h2: scl_n_nxt = 1'b0;
                  2'h3: begin
                     shf_nxt = (pair_r ? ADDR_PAIR1_WR : ADDR_PAIR0_WR)
                               | {7'h00, stg_r == STG_ADDR_RD};
                     sda_n_nxt = shf_nxt[7];
                     bcnt_nxt  = 4'h0;
                     st_nxt    = H_SEND;
                  end
               endcase
            end
         end
         H_SEND, H_RECV: begin
            if (tick) begin
               unique case (q_r)
                  2'h0: begin
                  end
                  2'h1: scl_n_nxt = 1'b1;
                  2'h2: begin
                     ack_nxt = s2_r[0];
                     if (st_r == H_RECV && bcnt_r < BITS_PER_BYTE)
                        shf_nxt = {shf_r[6:0], s2_r[0]};
                  end
                  2'h3: begin
                     scl_n_nxt = 1'b0;
                     bcnt_nxt  = bcnt_r + 4'h1;
                     sda_n_nxt = 1'b1;
                     if (bcnt_r < BITS_PER_BYTE - 4'h1) begin
                        if (st_r == H_SEND) begin
                           shf_nxt   = {shf_r[6:0], 1'b0};
                           sda_n_nxt = shf_r[6];
                        end
                     end else if (bcnt_r == BITS_PER_BYTE - 4'h1) begin
                        if (st_r == H_RECV)
                           sda_n_nxt = (len_r == 8'h01);
                     end else if (st_r == H_RECV) begin
                        rv_nxt   = 1'b1;
                        rdat_nxt = shf_r;
                        len_nxt  = len_r - 8'h01;
                        bcnt_nxt = 4'h0;
                        if (len_r == 8'h01) begin
                           sda_n_nxt = 1'b0;
                           st_nxt    = H_STOP;
                        end
                     end else if (ack_r) begin
                        nack_nxt  = 1'b1;
                        sda_n_nxt = 1'b0;
                        st_nxt    = H_STOP;
                     end else begin
                        bcnt_nxt = 4'h0;
                        unique case (stg_r)
                           STG_ADDR_WR: begin
                              stg_nxt = STG_PTR_HI;
                              shf_nxt = ptr_r[15:8];
                           end
                           STG_PTR_HI: begin
                              stg_nxt = STG_PTR_LO;
                              shf_nxt = ptr_r[7:0];
                           end
                           STG_ADDR_RD: begin
                              stg_nxt = STG_READ;
                              st_nxt  = H_RECV;
                           end
                           default: begin
                              stg_nxt = STG_DATA;
                              if (rd_r) begin
                                 stg_nxt = STG_ADDR_RD;
                                 st_nxt  = H_START;
                              end else if (len_r == 8'h00) begin
                                 sda_n_nxt = 1'b0;
                                 st_nxt    = H_STOP;
                              end else begin
                                 take_nxt = 1'b1;
                                 shf_nxt  = WR_DATA;
                                 len_nxt  = len_r - 8'h01;
                              end
                           end
                        endcase
                        if (st_nxt == H_SEND) sda_n_nxt = shf_nxt[7];
                     end
                  end
               endcase
            end
         end
         H_STOP: begin
            if (tick) begin
               unique case (q_r)
                  // one quarter for the slave to drop its ack first
                  2'h0: begin
                  end
                  2'h1: scl_n_nxt = 1'b1;
                  2'h2: sda_n_nxt = 1'b1;
                  2'h3: begin
                     done_nxt = 1'b1;
                     rdy_nxt  = 1'b1;
                     st_nxt   = H_IDLE;
                  end
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         st_r <= H_POR; por_r <= 16'h0000; ptr_r <= 16'h0000;
         cnt_r <= 8'h00; shf_r <= 8'h00; len_r <= 8'h00;
         rdat_r <= 8'h00; bcnt_r <= 4'h0; stg_r <= STG_ADDR_WR;
         q_r <= 2'h0; rd_r <= 1'b0; pair_r <= 1'b0; ack_r <= 1'b1;
         scl_n_r <= 1'b1; sda_n_r <= 1'b1; rst_r <= 1'b0;
         ioe_n_r <= 1'b0; rdy_r <= 1'b0; take_r <= 1'b0;
         rv_r <= 1'b0; done_r <= 1'b0; nack_r <= 1'b0;
      end else if (CE) begin
         st_r <= st_nxt; por_r <= por_nxt; ptr_r <= ptr_nxt;
         cnt_r <= cnt_nxt; shf_r <= shf_nxt; len_r <= len_nxt;
         rdat_r <= rdat_nxt; bcnt_r <= bcnt_nxt; stg_r <= stg_nxt;
         q_r <= q_nxt; rd_r <= rd_nxt; pair_r <= pair_nxt;
         ack_r <= ack_nxt; scl_n_r <= scl_n_nxt; sda_n_r <= sda_n_nxt;
         rst_r <= rst_nxt; ioe_n_r <= ioe_n_nxt; rdy_r <= rdy_nxt;
         take_r <= take_nxt; rv_r <= rv_nxt; done_r <= done_nxt;
         nack_r <= nack_nxt;
      end
   end

   // =========================================================
   // outputs; clock and data are open drain, low when enabled
   assign LINK.h_scl_o    = 1'b0;
   assign LINK.h_scl_oe_n = scl_n_r;
   assign LINK.h_sda_o    = 1'b0;
   assign LINK.h_sda_oe_n = sda_n_r;
   assign LINK.h_rst_n    = rst_r;
   assign LINK.h_int_o    = pair_r;
   assign LINK.h_int_oe_n = ioe_n_r;
   assign CMD_READY       = rdy_r;
   assign WR_TAKE         = take_r;
   assign RD_VALID        = rv_r;
   assign RD_DATA         = rdat_r;
   assign DONE            = done_r;
   assign NACK            = nack_r;
   assign EVENT           = s2_r[1];
endmodule : tsl_host
`default_nettype wire

// file: sim/tsl_chk.sv
// link checker between the host end and the touch slave
// assumes the link interface resolves the open-drain lines
`timescale 1ns/100ps
`default_nettype none
module tsl_chk (
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic scl,
   input wire logic sda,
   input wire logic rst_n,
   input wire logic h_sda_oe_n,
   input wire logic d_sda_oe_n,
   input wire logic h_int_oe_n,
   input wire logic d_int_oe_n
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   // =========================================================
   // link rules
   a_quiet_in_reset: assert property (!rst_n [*4] |-> d_sda_oe_n)
      else $error("slave drives data in link reset");
   a_sda_on_low: assert property ($changed(d_sda_oe_n) |->
      !scl && !$past(scl)) else $error("slave moved data with clock high");
   a_event_driven: assert property ((rst_n && h_int_oe_n) [*5]
      |-> !d_int_oe_n) else $error("event line not driven");
   a_clock_high_min: assert property ($rose(scl) |-> scl [*3])
      else $error("clock high too short");
   a_clock_low_min: assert property ($fell(scl) |-> !scl [*3])
      else $error("clock low too short");
   a_start_by_host: assert property ($fell(sda) && scl && $past(scl)
      |-> !h_sda_oe_n) else $error("start not made by host");
   a_stop_quiet: assert property ($rose(sda) && scl && $past(scl)
      |-> d_sda_oe_n [*8]) else $error("slave active after stop");
   // slave may hold the line for an ack plus one zero bit at most
   a_drive_bounded: assert property ($fell(d_sda_oe_n) |->
      ##[1:30] $rose(d_sda_oe_n)) else $error("slave held data too long");
   c_start: cover property ($fell(sda) && scl);
   c_slave_low: cover property ($fell(d_sda_oe_n));
   c_stop: cover property ($rose(sda) && scl);
endmodule : tsl_chk
`default_nettype wire

// file: sim/tb_touch_i2c_register_slave.sv
// bench: host end and touch slave joined by the link interface
// assumes a 256-entry register model answering the slave pointer
`timescale 1ns/100ps
`default_nettype none
module tb_touch_i2c_register_slave;
   import tsl_pkg::*;
   logic        clk, rstn, pair, ev, c_valid, c_rd, ready, take;
   logic        rvalid, done, nack, wr, d_pair, h_ev;
   logic [15:0] c_ptr, raddr;
   logic [7:0]  c_len, wdat, rdat, wbyte, a, b;
   logic [7:0]  mem [0:255];
   int          err_count, compares;
   int          cyc = 0;
   tsl_link_if link();
   tsl_dev tsl_dev_inst (.CLK_SYS(clk), .RSTN(rstn), .CE(1'b1),
      .LINK(link.dev), .EVENT(ev), .REG_RDATA(mem[raddr[7:0]]),
      .REG_ADDR(raddr), .REG_WR(wr), .REG_WDATA(wbyte), .REG_RD(),
      .PAIR_SEL(d_pair));
   tsl_host #(.QTR(3), .POR(8)) tsl_host_inst (.CLK_SYS(clk),
      .RSTN(rstn), .CE(1'b1), .LINK(link.host), .PAIR_SEL(pair),
      .CMD_VALID(c_valid), .CMD_RD(c_rd), .CMD_PTR(c_ptr),
      .CMD_LEN(c_len), .WR_DATA(wdat), .CMD_READY(ready),
      .WR_TAKE(take), .RD_VALID(rvalid), .RD_DATA(rdat), .DONE(done),
      .NACK(nack), .EVENT(h_ev));
   tsl_chk tsl_chk_inst (.CLK_SYS(clk), .RSTN(rstn), .scl(link.scl),
      .sda(link.sda), .rst_n(link.rst_n), .h_sda_oe_n(link.h_sda_oe_n),
      .d_sda_oe_n(link.d_sda_oe_n), .h_int_oe_n(link.h_int_oe_n),
      .d_int_oe_n(link.d_int_oe_n));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      if (wr === 1'b1)
         mem[raddr[7:0]] <= wbyte;
   end
   // =========================================================
   // report helpers
   task automatic chk(input string nm, input logic [15:0] s, e);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   // hang guard: whole run needs well under 10000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         finish_test();
      end
   end
   // =========================================================
   // one host command, checking read bytes as they arrive
   task automatic xfer(input logic r, input logic [15:0] p,
                       input logic [7:0] n, d0, d1);
      int k;
      k = 0;
      do @(negedge clk); while (ready !== 1'b1);
      c_rd = r;
      c_ptr = p;
      c_len = n;
      wdat = d0;
      c_valid = 1'b1;
      @(negedge clk);
      c_valid = 1'b0;
      while (done !== 1'b1) begin
         if (take === 1'b1)
            wdat = d1;
         if (rvalid === 1'b1) begin
            chk("rd_data", {8'h00, rdat}, {8'h00, k ? d1 : d0});
            k++;
         end
         @(negedge clk);
      end
      chk("nack", {15'h0, nack}, 16'h0000);
   endtask : xfer
   // =========================================================
   // main sequence, once per address pair
   initial begin
      {rstn, pair, ev, c_valid, c_rd} = 5'h00;
      c_ptr = 16'h0000;
      c_len = 8'h00;
      wdat = 8'h00;
      for (int p = 0; p < 2; p++) begin
         rstn = 1'b0;
         pair = p[0];
         ev = p[0];
         a = p[0] ? 8'h55 : 8'hAA;
         b = ~a;
         repeat (4) @(negedge clk);
         rstn = 1'b1;
         xfer(1'b0, 16'h0010, 8'h02, a, b);
         chk("mem10", {8'h00, mem[8'h10]}, {8'h00, a});
         chk("mem11", {8'h00, mem[8'h11]}, {8'h00, b});
         chk("pair", {15'h0, d_pair}, {15'h0, pair});
         xfer(1'b1, 16'h0010, 8'h02, a, b);
         xfer(1'b0, 16'h0011, 8'h00, 8'h00, 8'h00);
         xfer(1'b1, 16'h0011, 8'h01, b, 8'h00);
         chk("event", {15'h0, h_ev}, {15'h0, ev});
         ev = ~ev;
         repeat (8) @(negedge clk);
         chk("event_tgl", {15'h0, h_ev}, {15'h0, ev});
         $display("test pair %0d done", p);
      end
      finish_test();
   end
endmodule : tb_touch_i2c_register_slave
`default_nettype wire
